// ===== logic/utrx_defs.vh
`ifndef UTRX_DEFS_VH
`define UTRX_DEFS_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define UTRX_RXA_GEN_ADDR 32'h0000_0228
`define UTRX_RXB_GEN_ADDR 32'h0000_0238
`define UTRX_STATUS_ADDR 32'h0000_023C

// ----------------------------------------
// Clock generator register layout
// ----------------------------------------
`define UTRX_GEN_RESET 16'h0403
`define UTRX_GEN_W 16
`define UTRX_DIV_MSB 5
`define UTRX_DIV_LSB 0
`define UTRX_LOAD_BIT 6
`define UTRX_INV_BIT 7
`define UTRX_SRC_MSB 10
`define UTRX_SRC_LSB 8
`define UTRX_OE_BIT 11
`define UTRX_PRES_BIT 12
`define UTRX_DRST_BIT 13
`define UTRX_STORE_MASK 16'hFFBF

// ----------------------------------------
// Source select codes
// ----------------------------------------
`define UTRX_SRC_TXA 3'h0
`define UTRX_SRC_TXB 3'h1
`define UTRX_SRC_TXC 3'h2
`define UTRX_SRC_RXA 3'h3
`define UTRX_SRC_RXB 3'h4
`define UTRX_SRC_RXC 3'h5
`define UTRX_SRC_MEM 3'h6
`define UTRX_NUM_SRC 7

// ----------------------------------------
// Status register layout
// ----------------------------------------
`define UTRX_ST_DIVA_LSB 0
`define UTRX_ST_DIVB_LSB 8
`define UTRX_ST_OUTA_BIT 16
`define UTRX_ST_OUTB_BIT 17

// ----------------------------------------
// Divider and bus constants
// ----------------------------------------
`define UTRX_CNT_INIT 6'h3F
`define UTRX_CNT_ONE 6'h01
`define UTRX_HTRANS_NONSEQ_BIT 1
`define UTRX_HRESP_OKAY 1'b0
`define UTRX_ZERO32 32'h0000_0000

`endif

// ===== logic/utrx_clk_gen.v
`timescale 1ns/1ps
`include "utrx_defs.vh"

module utrx_clk_gen #(
  parameter DIV_W = 6
) (
  input wire ref_clk_i,
  input wire srst_i,
  input wire src_rise_i,
  input wire src_fall_i,
  input wire [DIV_W-1:0] div_i,
  input wire load_now_i,
  input wire div_run_i,
  output wire clk_o,
  output wire [DIV_W-1:0] div_act_o
);

  reg [DIV_W-1:0] cnt_q;
  reg [DIV_W-1:0] div_act_q;
  reg out_q;
  wire [DIV_W-1:0] eff;
  wire [DIV_W-1:0] half;
  wire [DIV_W-1:0] cnt_inc;
  wire wrap;

  // Divide by zero behaves as divide by one
  assign eff = (div_act_q == {DIV_W{1'b0}}) ? `UTRX_CNT_ONE : div_act_q;
  assign half = eff >> 1;
  assign cnt_inc = cnt_q + `UTRX_CNT_ONE;
  assign wrap = (cnt_q >= (eff - `UTRX_CNT_ONE));

  // ----------------------------------------
  // Divider
  // ----------------------------------------
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      cnt_q <= `UTRX_CNT_INIT;
      div_act_q <= {DIV_W{1'b0}};
      out_q <= 1'b0;
    end else if (!div_run_i) begin
      cnt_q <= `UTRX_CNT_INIT;
      div_act_q <= div_i;
      out_q <= 1'b0;
    end else if (load_now_i) begin
      cnt_q <= `UTRX_CNT_INIT;
      div_act_q <= div_i;
      out_q <= 1'b0;
    end else if (src_rise_i) begin
      if (wrap) begin
        cnt_q <= {DIV_W{1'b0}};
        div_act_q <= div_i;
        out_q <= 1'b1;
      end else begin
        cnt_q <= cnt_inc;
        if (!eff[0] && (cnt_inc == half)) begin
          out_q <= 1'b0;
        end
      end
    // odd divisor falls on source fall
    end else if (src_fall_i && eff[0] && (cnt_q == half)) begin
      out_q <= 1'b0;
    end
  end

  assign clk_o = out_q;
  assign div_act_o = div_act_q;

endmodule // utrx_clk_gen

// ===== logic/utrx_top.v
`timescale 1ns/1ps
`include "utrx_defs.vh"


module utrx_top #(
  parameter DIV_W = 6,
  parameter NUM_PORT = 2
) (
  input wire ref_clk_i,
  input wire srst_i,
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire hready_i,
  input wire [31:0] hwdata_i,
  output reg [31:0] hrdata_o,
  output reg hreadyout_o,
  output reg hresp_o,
  input wire tx_a_clk_i,
  input wire tx_b_clk_i,
  input wire tx_c_clk_i,
  input wire rx_a_clk_i,
  input wire rx_b_clk_i,
  input wire rx_c_clk_i,
  input wire mem_clk_i,
  output reg rx_a_clk_o,
  output reg rx_a_clk_oe_o,
  output reg rx_b_clk_o,
  output reg rx_b_clk_oe_o
);

  // ----------------------------------------
  // Source clock synchronisers
  // ----------------------------------------
  // Sources are sampled, so each must stay well below a quarter of ref_clk_i
  wire [`UTRX_NUM_SRC-1:0] src_pin;
  reg [`UTRX_NUM_SRC-1:0] src_s1_q;
  reg [`UTRX_NUM_SRC-1:0] src_s2_q;
  reg [`UTRX_NUM_SRC-1:0] src_s3_q;
  wire [`UTRX_NUM_SRC-1:0] src_rise;
  wire [`UTRX_NUM_SRC-1:0] src_fall;

  assign src_pin = {mem_clk_i, rx_c_clk_i, rx_b_clk_i, rx_a_clk_i,
                    tx_c_clk_i, tx_b_clk_i, tx_a_clk_i};

  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      src_s1_q <= {`UTRX_NUM_SRC{1'b0}};
      src_s2_q <= {`UTRX_NUM_SRC{1'b0}};
      src_s3_q <= {`UTRX_NUM_SRC{1'b0}};
    end else begin
      src_s1_q <= src_pin;
      src_s2_q <= src_s1_q;
      src_s3_q <= src_s2_q;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `UTRX_NUM_SRC; gi = gi + 1) begin : g_edge
      assign src_rise[gi] = src_s2_q[gi] & ~src_s3_q[gi];
      assign src_fall[gi] = ~src_s2_q[gi] & src_s3_q[gi];
    end
  endgenerate

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // source select decode
  function pick_src;
    input [2:0] code;
    input [`UTRX_NUM_SRC-1:0] vec;
    begin
      case (code)
        `UTRX_SRC_TXA: pick_src = vec[`UTRX_SRC_TXA];
        `UTRX_SRC_TXB: pick_src = vec[`UTRX_SRC_TXB];
        `UTRX_SRC_TXC: pick_src = vec[`UTRX_SRC_TXC];
        `UTRX_SRC_RXA: pick_src = vec[`UTRX_SRC_RXA];
        `UTRX_SRC_RXB: pick_src = vec[`UTRX_SRC_RXB];
        `UTRX_SRC_RXC: pick_src = vec[`UTRX_SRC_RXC];
        `UTRX_SRC_MEM: pick_src = vec[`UTRX_SRC_MEM];
        // Reserved code gives no edges, so the output parks
        default: pick_src = 1'b0;
      endcase
    end
  endfunction

  // Pulse bit is never stored
  function [`UTRX_GEN_W-1:0] store_val;
    input [31:0] wdata;
    begin
      store_val = wdata[`UTRX_GEN_W-1:0] & `UTRX_STORE_MASK;
    end
  endfunction

  // ----------------------------------------
  // AHB-Lite slave
  // ----------------------------------------
  reg [`UTRX_GEN_W-1:0] gen_a_q;
  reg [`UTRX_GEN_W-1:0] gen_b_q;
  reg [NUM_PORT-1:0] load_q;
  reg wr_pend_q;
  reg [31:0] wr_addr_q;
  wire addr_phase;
  wire wr_a;
  wire wr_b;
  wire [`UTRX_GEN_W-1:0] rd_a;
  wire [`UTRX_GEN_W-1:0] rd_b;
  wire [NUM_PORT-1:0] gen_out;
  wire [NUM_PORT*DIV_W-1:0] div_act;
  wire [31:0] status;
  reg [31:0] rd_mux;

  assign addr_phase = hsel_i & hready_i & htrans_i[`UTRX_HTRANS_NONSEQ_BIT];
  assign wr_a = wr_pend_q && (wr_addr_q == `UTRX_RXA_GEN_ADDR);
  assign wr_b = wr_pend_q && (wr_addr_q == `UTRX_RXB_GEN_ADDR);
  // Forward a write still in its data phase to a following read
  assign rd_a = wr_a ? store_val(hwdata_i) : gen_a_q;
  assign rd_b = wr_b ? store_val(hwdata_i) : gen_b_q;

  assign status = {14'h0000, gen_out[1], gen_out[0],
                   2'h0, div_act[2*DIV_W-1:DIV_W], 2'h0, div_act[DIV_W-1:0]};

  always @* begin
    if (haddr_i == `UTRX_RXA_GEN_ADDR) begin
      rd_mux = {16'h0000, rd_a};
    end else if (haddr_i == `UTRX_RXB_GEN_ADDR) begin
      rd_mux = {16'h0000, rd_b};
    end else if (haddr_i == `UTRX_STATUS_ADDR) begin
      rd_mux = status;
    end else begin
      rd_mux = `UTRX_ZERO32;
    end
  end

  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= `UTRX_ZERO32;
      hrdata_o <= `UTRX_ZERO32;
      hreadyout_o <= 1'b0;
      hresp_o <= `UTRX_HRESP_OKAY;
    end else begin
      // Zero wait states: every transfer completes in one data phase
      hreadyout_o <= 1'b1;
      hresp_o <= `UTRX_HRESP_OKAY;
      wr_pend_q <= addr_phase & hwrite_i;
      if (addr_phase) begin
        wr_addr_q <= haddr_i;
      end
      if (addr_phase && !hwrite_i) begin
        hrdata_o <= rd_mux;
      end
    end
  end

  // ----------------------------------------
  // Clock generator registers
  // ----------------------------------------
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      gen_a_q <= `UTRX_GEN_RESET;
      gen_b_q <= `UTRX_GEN_RESET;
      load_q <= {NUM_PORT{1'b0}};
    end else begin
      if (wr_a) begin
        gen_a_q <= store_val(hwdata_i);
      end
      if (wr_b) begin
        gen_b_q <= store_val(hwdata_i);
      end
      load_q <= {wr_b & hwdata_i[`UTRX_LOAD_BIT], wr_a & hwdata_i[`UTRX_LOAD_BIT]};
    end
  end

  // ----------------------------------------
  // Per-port generators
  // ----------------------------------------
  wire [NUM_PORT*`UTRX_GEN_W-1:0] gen_all;

  assign gen_all = {gen_b_q, gen_a_q};

  generate
    for (gi = 0; gi < NUM_PORT; gi = gi + 1) begin : g_port
      wire [`UTRX_GEN_W-1:0] cfg;
      wire [2:0] sel;

      assign cfg = gen_all[gi*`UTRX_GEN_W +: `UTRX_GEN_W];
      assign sel = cfg[`UTRX_SRC_MSB:`UTRX_SRC_LSB];

      utrx_clk_gen #(
        .DIV_W(DIV_W)
      ) u_gen (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .src_rise_i(pick_src(sel, src_rise)),
        .src_fall_i(pick_src(sel, src_fall)),
        .div_i(cfg[`UTRX_DIV_MSB:`UTRX_DIV_LSB]),
        .load_now_i(load_q[gi]),
        .div_run_i(cfg[`UTRX_DRST_BIT]),
        .clk_o(gen_out[gi]),
        .div_act_o(div_act[gi*DIV_W +: DIV_W])
      );
    end
  endgenerate

  // ----------------------------------------
  // Port clock pins
  // ----------------------------------------
  // Selecting a port's own pin as its source while driving it forms a loop
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      rx_a_clk_o <= 1'b0;
      rx_a_clk_oe_o <= 1'b0;
      rx_b_clk_o <= 1'b0;
      rx_b_clk_oe_o <= 1'b0;
    end else begin
      rx_a_clk_o <= gen_out[0] ^ gen_a_q[`UTRX_INV_BIT];
      rx_b_clk_o <= gen_out[1] ^ gen_b_q[`UTRX_INV_BIT];
      rx_a_clk_oe_o <= gen_a_q[`UTRX_OE_BIT];
      rx_b_clk_oe_o <= gen_b_q[`UTRX_OE_BIT];
    end
  end

endmodule // utrx_top

// ===== test/utrx_src_model.sv
`timescale 1ns/1ps
// ---------
// Source clocks
// ---------
module utrx_src_model (
  input wire logic slow_i,
  output logic [6:0] clk_o
);
  // Fractional start keeps edges off the ref clock edges
  for (genvar k = 0; k < 7; k++) begin : g_src
    initial begin
      clk_o[k] = 1'h0;
      #(1.3 + k);
      forever #((30 + 10 * k) * (slow_i ? 2 : 1)) clk_o[k] = ~clk_o[k];
    end
  end
endmodule // utrx_src_model

// ===== test/utrx_top_chk.sv
`timescale 1ns/1ps
`include "utrx_defs.vh"
// ---------
// Port checks
// ---------
module utrx_top_chk (
  input wire ref_clk_i,
  input wire srst_i,
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire hready_i,
  input wire [31:0] hwdata_i,
  input wire hreadyout_o,
  input wire hresp_o,
  input wire rx_a_clk_o,
  input wire rx_a_clk_oe_o,
  input wire rx_b_clk_o,
  input wire rx_b_clk_oe_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  // Shadows; age saturates so checks wait out pin latency
  logic wa_q, wb_q;
  logic [15:0] sa_q, sb_q;
  logic [2:0] ca_q, cb_q;
  wire wr = hsel_i & hready_i & htrans_i[1] & hwrite_i;
  always_ff @(posedge ref_clk_i) begin
    wa_q <= wr && haddr_i == `UTRX_RXA_GEN_ADDR && !srst_i;
    wb_q <= wr && haddr_i == `UTRX_RXB_GEN_ADDR && !srst_i;
    sa_q <= srst_i ? `UTRX_GEN_RESET : wa_q ? hwdata_i[15:0] : sa_q;
    sb_q <= srst_i ? `UTRX_GEN_RESET : wb_q ? hwdata_i[15:0] : sb_q;
    ca_q <= (srst_i || wa_q) ? 3'h0 : ca_q + {2'h0, ca_q != 3'h7};
    cb_q <= (srst_i || wb_q) ? 3'h0 : cb_q + {2'h0, cb_q != 3'h7};
  end
  property p_okay; hresp_o == 1'h0; endproperty
  a_okay: assert property (p_okay) else $error("bad response");
  property p_rdy; $fell(srst_i) |-> !hreadyout_o ##1 hreadyout_o [*4]; endproperty
  a_rdy: assert property (p_rdy) else $error("ready wrong after reset");
  property p_rst; $fell(srst_i) |-> !(rx_a_clk_o | rx_a_clk_oe_o | rx_b_clk_o | rx_b_clk_oe_o);
  endproperty
  a_rst: assert property (p_rst) else $error("pins not idle after reset");
  property p_oe_a; ca_q > 3'h2 |-> rx_a_clk_oe_o == sa_q[`UTRX_OE_BIT]; endproperty
  a_oe_a: assert property (p_oe_a) else $error("enable A wrong");
  property p_oe_b; cb_q > 3'h2 |-> rx_b_clk_oe_o == sb_q[`UTRX_OE_BIT]; endproperty
  a_oe_b: assert property (p_oe_b) else $error("enable B wrong");
  property p_hold_a;
    ca_q == 3'h7 && !sa_q[`UTRX_DRST_BIT] |-> rx_a_clk_o == sa_q[`UTRX_INV_BIT];
  endproperty
  a_hold_a: assert property (p_hold_a) else $error("held clock A wrong");
  property p_hold_b;
    cb_q == 3'h7 && !sb_q[`UTRX_DRST_BIT] |-> rx_b_clk_o == sb_q[`UTRX_INV_BIT];
  endproperty
  a_hold_b: assert property (p_hold_b) else $error("held clock B wrong");
  property p_gap_a; ca_q == 3'h7 && $changed(rx_a_clk_o) |=> $stable(rx_a_clk_o); endproperty
  a_gap_a: assert property (p_gap_a) else $error("clock A too fast");
  property p_gap_b; cb_q == 3'h7 && $changed(rx_b_clk_o) |=> $stable(rx_b_clk_o); endproperty
  a_gap_b: assert property (p_gap_b) else $error("clock B too fast");
  c_run_a: cover property ($rose(rx_a_clk_o));
  c_run_b: cover property ($rose(rx_b_clk_o));
  c_inv: cover property (ca_q == 3'h7 && sa_q[`UTRX_INV_BIT] && rx_a_clk_o);
endmodule // utrx_top_chk

bind utrx_top utrx_top_chk u_utrx_top_chk (.ref_clk_i, .srst_i, .hsel_i, .haddr_i, .htrans_i,
  .hwrite_i, .hready_i, .hwdata_i, .hreadyout_o, .hresp_o, .rx_a_clk_o, .rx_a_clk_oe_o,
  .rx_b_clk_o, .rx_b_clk_oe_o);

// ===== test/utrx_top_bench.sv
`timescale 1ns/1ps
`include "utrx_defs.vh"
// ---------
// Register driven clock tests
// ---------
module utrx_top_bench;
  logic ref_clk_i, srst_i, hsel_i, hwrite_i, slow;
  logic [31:0] haddr_i, hwdata_i, rd;
  logic [1:0] htrans_i;
  logic [2:0] hsize_i;
  wire [31:0] hrdata_o;
  wire hreadyout_o, hresp_o, rx_a_clk_o, rx_a_clk_oe_o, rx_b_clk_o, rx_b_clk_oe_o;
  wire hready_i = hreadyout_o;
  wire [6:0] src;
  int bad_count, cmp_count;
  utrx_top u_utrx_top (.ref_clk_i, .srst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i,
    .hready_i, .hwdata_i, .hrdata_o, .hreadyout_o, .hresp_o, .tx_a_clk_i(src[0]),
    .tx_b_clk_i(src[1]), .tx_c_clk_i(src[2]), .rx_a_clk_i(src[3]), .rx_b_clk_i(src[4]),
    .rx_c_clk_i(src[5]), .mem_clk_i(src[6]), .rx_a_clk_o, .rx_a_clk_oe_o, .rx_b_clk_o,
    .rx_b_clk_oe_o);
  utrx_src_model u_utrx_src_model (.slow_i(slow), .clk_o(src));
  initial begin
    ref_clk_i = 1'h0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  task give_verdict;
    if (bad_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Edge times carry one ref cycle of sync jitter each
  task near(input int got, input int exp);
    cmp_count++;
    if (got > exp + 20 || got + 20 < exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (hreadyout_o !== 1'h1 && n < 100);
    if (hreadyout_o !== 1'h1) begin
      bad_count++;
      give_verdict;
    end
  endtask
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel_i <= 1'h1;
    haddr_i <= a;
    hwrite_i <= w;
    htrans_i <= 2'h2;
    wait_rdy;
    hsel_i <= 1'h0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    wait_rdy;
    rd = hrdata_o;
  endtask
  task wpin(input bit b, input logic v);
    int n;
    n = 0;
    while ((b ? rx_b_clk_o : rx_a_clk_o) !== v && n < 4000) begin
      @(posedge ref_clk_i);
      n++;
    end
    if (n >= 4000) begin
      bad_count++;
      give_verdict;
    end
  endtask
  task meas(input bit b, input int n, input int h);
    int t0, t1;
    wpin(b, 1'h0);
    wpin(b, 1'h1);
    t0 = int'($time);
    wpin(b, 1'h0);
    t1 = int'($time);
    wpin(b, 1'h1);
    near(t1 - t0, n * h);
    near(int'($time) - t0, 2 * n * h);
  endtask
  initial begin
    srst_i = 1'h1;
    hsel_i = 1'h0;
    haddr_i = 32'h0;
    hwrite_i = 1'h0;
    htrans_i = 2'h0;
    hsize_i = 3'h2;
    hwdata_i = 32'h0;
    slow = 1'h0;
    bad_count = 0;
    cmp_count = 0;
    repeat (12) @(posedge ref_clk_i);
    srst_i <= 1'h0;
    xfer(1'h0, `UTRX_RXA_GEN_ADDR, 32'h0);
    chk(rd, 32'h403);
    xfer(1'h0, `UTRX_RXB_GEN_ADDR, 32'h0);
    chk(rd, 32'h403);
    xfer(1'h1, 32'h230, 32'hFFFF);
    xfer(1'h0, 32'h230, 32'h0);
    chk(rd, 32'h0);
    xfer(1'h1, `UTRX_RXA_GEN_ADDR, 32'h8C5);
    xfer(1'h0, `UTRX_RXA_GEN_ADDR, 32'h0);
    chk(rd, 32'h885);
    repeat (10) @(posedge ref_clk_i);
    chk({31'h0, rx_a_clk_o}, 32'h1);
    chk({31'h0, rx_a_clk_oe_o}, 32'h1);
    for (int k = 0; k < 7; k++) begin
      xfer(1'h1, `UTRX_RXA_GEN_ADDR, 32'h3800 | (k << 8) | (k + 1));
      xfer(1'h1, `UTRX_RXB_GEN_ADDR, 32'h3800 | (k << 8) | (7 - k));
      meas(1'h0, k + 1, 30 + 10 * k);
      meas(1'h1, 7 - k, 30 + 10 * k);
    end
    xfer(1'h1, `UTRX_RXA_GEN_ADDR, 32'h3E02);
    meas(1'h0, 2, 90);
    xfer(1'h1, `UTRX_RXA_GEN_ADDR, 32'h2E45);
    meas(1'h0, 5, 90);
    slow <= 1'h1;
    repeat (40) @(posedge ref_clk_i);
    meas(1'h1, 1, 180);
    // Reserved source code gives no edges: pin must park
    xfer(1'h1, `UTRX_RXA_GEN_ADDR, 32'h3F02);
    repeat (10) @(posedge ref_clk_i);
    rd = {31'h0, rx_a_clk_o};
    repeat (100) @(posedge ref_clk_i);
    chk({31'h0, rx_a_clk_o}, rd);
    xfer(1'h1, `UTRX_RXB_GEN_ADDR, 32'h601);
    repeat (10) @(posedge ref_clk_i);
    chk({31'h0, rx_b_clk_oe_o}, 32'h0);
    chk({31'h0, rx_b_clk_o}, 32'h0);
    // Active divisors: A kept the loaded 5, B follows its register while held
    xfer(1'h0, `UTRX_STATUS_ADDR, 32'h0);
    chk(rd & 32'h0000_3F3F, 32'h0000_0105);
    give_verdict;
  end
endmodule // utrx_top_bench
